// [core/sspp_params.svh]
// constants of the synthesizer serial programming port
// assumes one clock domain; included by bare name where needed
`ifndef SSPP_PARAMS_SVH
`define SSPP_PARAMS_SVH

// serial word layout: data field shifted first, address field last
`define SSPP_WORD_W      22
`define SSPP_DATA_W      18
`define SSPP_ADDR_W      4
`define SSPP_ADDR_LSB    0
`define SSPP_DATA_LSB    4

// internal register addresses
`define SSPP_ADDR_MAIN   4'h0
`define SSPP_ADDR_PWR    4'h2
`define SSPP_ADDR_RF1_N  4'h3
`define SSPP_ADDR_RF2_N  4'h4
`define SSPP_ADDR_IF_N   4'h5
`define SSPP_ADDR_RF1_R  4'h6
`define SSPP_ADDR_RF2_R  4'h7
`define SSPP_ADDR_IF_R   4'h8

// field positions inside the data field
`define SSPP_PWR_RF_BIT  0
`define SSPP_PWR_IF_BIT  1
`define SSPP_IFDIV_LSB   10
`define SSPP_IFDIV_W     2

// reset values
`define SSPP_PWR_RST     1'b1
`define SSPP_IFDIV_RST   2'h0
`define SSPP_RF1_SEL_RST 1'b1
// synchroniser reset at pin idle levels: powerdown and strobe high, clock and data low
`define SSPP_PIN_RST     4'hc

// self-tune length in phase-detector update periods
`define SSPP_TUNE_PERIODS 13

`endif

// [core/sspp_pkg.sv]
// types shared by the serial programming port files
// assumes sspp_params.svh is available on the include path
package sspp_pkg;

    // output divide codes for the if path: 1, 2, 4, 8
    typedef enum logic [1:0] {
        SSPP_DIV1,
        SSPP_DIV2,
        SSPP_DIV4,
        SSPP_DIV8
    } sspp_if_div_t;

    // self-tune sequencer states
    typedef enum logic {
        SSPP_TUNE_IDLE,
        SSPP_TUNE_RUN
    } sspp_tune_state_t;

endpackage

// [core/sspp_top.sv]
// serial programming port of a triple-loop synthesizer with the control
// behaviour that register writes trigger: rf loop select, power, if divide
// and self-tune sequencing
// assumes sclk, serial_in, load_strobe_n and powerdown_pin_n are pins from
// outside the clk domain, sclk well below clk/4; pd ticks come from clk logic
//
// Notes on behaviour
// - a word is 22 bits: 18-bit data field plus 4-bit register address
// - with the strobe low, serial data shifts in on each rising shift clock
// - strobe rising edge copies the data field into the addressed register
// - with the strobe high, shift clock and data are ignored, shifter holds
// - extra leading bits fall out; only the last 22 bits are kept
// - only one rf loop active; the last one whose register was written
// - self-tune starts on loop powerup by pin or write, and on new frequency
// - if output divider selects divide by one, two, four or eight
// - two power bits in one register: one powers a loop up, zero down
// - self-tune lasts the first 13 update periods before the loop takes over
`timescale 1ns/100ps
`include "sspp_params.svh"

module sspp_top #(
    parameter int WORD_W       = `SSPP_WORD_W,
    parameter int TUNE_PERIODS = `SSPP_TUNE_PERIODS
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    sclk,
    input  wire logic                    serial_in,
    input  wire logic                    load_strobe_n,
    input  wire logic                    powerdown_pin_n,
    input  wire logic                    pd_tick_rf,
    input  wire logic                    pd_tick_if,
    output logic                         rf1_active,
    output logic                         rf2_active,
    output logic                         rf_loop_on,
    output logic                         if_loop_on,
    output logic [`SSPP_IFDIV_W-1:0]     if_div_sel,
    output logic                         rf_tuning,
    output logic                         if_tuning,
    output logic                         wr_stb,
    output logic [`SSPP_ADDR_W-1:0]      wr_addr,
    output logic [`SSPP_DATA_W-1:0]      wr_data
);

    // two-flop synchronisers for the four pins; stage one feeds stage two only
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_prev_r;
    logic       sclk_s;
    logic       sdat_s;
    logic       strb_n_s;
    logic       pdn_n_s;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_s1_r   <= `SSPP_PIN_RST; // idle levels, so no false edge after reset
            pin_s2_r   <= `SSPP_PIN_RST;
            pin_prev_r <= `SSPP_PIN_RST;
        end else begin
            pin_s1_r   <= {powerdown_pin_n, load_strobe_n, serial_in, sclk};
            pin_s2_r   <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    assign sclk_s   = pin_s2_r[0];
    assign sdat_s   = pin_s2_r[1];
    assign strb_n_s = pin_s2_r[2];
    assign pdn_n_s  = pin_s2_r[3];

    // edge detection on the synchronised copies
    logic sclk_rise;
    logic strb_rise;

    assign sclk_rise = sclk_s & ~pin_prev_r[0];
    assign strb_rise = strb_n_s & ~pin_prev_r[2];

    // shifter and write strobe
    logic [WORD_W-1:0]       shift_r;
    logic [WORD_W-1:0]       shift_nxt;
    logic                    wr_stb_r;
    logic                    wr_stb_nxt;
    logic [`SSPP_ADDR_W-1:0] wr_addr_r;
    logic [`SSPP_ADDR_W-1:0] wr_addr_nxt;
    logic [`SSPP_DATA_W-1:0] wr_data_r;
    logic [`SSPP_DATA_W-1:0] wr_data_nxt;

    // a shift register of exactly one word drops older bits by itself
    always_comb begin
        shift_nxt   = shift_r;
        wr_stb_nxt  = 1'b0;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        if (!strb_n_s && sclk_rise) begin
            shift_nxt = {shift_r[WORD_W-2:0], sdat_s};
        end
        if (strb_rise) begin
            wr_stb_nxt  = 1'b1;
            wr_addr_nxt = shift_r[`SSPP_ADDR_LSB +: `SSPP_ADDR_W];
            wr_data_nxt = shift_r[`SSPP_DATA_LSB +: `SSPP_DATA_W];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            shift_r   <= '0;
            wr_stb_r  <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else begin
            shift_r   <= shift_nxt;
            wr_stb_r  <= wr_stb_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

    // control state updated from the latched word one cycle after strobe
    logic                        rf1_sel_r;
    logic                        rf1_sel_nxt;
    logic                        rf2_sel_r;
    logic                        rf2_sel_nxt;
    logic                        pwr_rf_r;
    logic                        pwr_rf_nxt;
    logic                        pwr_if_r;
    logic                        pwr_if_nxt;
    sspp_pkg::sspp_if_div_t      if_div_r;
    sspp_pkg::sspp_if_div_t      if_div_nxt;
    logic                        rf_on_r;
    logic                        rf_on_nxt;
    logic                        if_on_r;
    logic                        if_on_nxt;
    logic                        rf_freq_r;
    logic                        rf_freq_nxt;
    logic                        if_freq_r;
    logic                        if_freq_nxt;

    always_comb begin
        rf1_sel_nxt = rf1_sel_r;
        pwr_rf_nxt  = pwr_rf_r;
        pwr_if_nxt  = pwr_if_r;
        if_div_nxt  = if_div_r;
        rf_freq_nxt = 1'b0;
        if_freq_nxt = 1'b0;
        if (wr_stb_r) begin
            unique case (wr_addr_r)
                `SSPP_ADDR_RF1_N, `SSPP_ADDR_RF1_R: begin
                    rf1_sel_nxt = 1'b1;
                    rf_freq_nxt = 1'b1;
                end
                `SSPP_ADDR_RF2_N, `SSPP_ADDR_RF2_R: begin
                    rf1_sel_nxt = 1'b0;
                    rf_freq_nxt = 1'b1;
                end
                `SSPP_ADDR_IF_N, `SSPP_ADDR_IF_R: begin
                    if_freq_nxt = 1'b1;
                end
                `SSPP_ADDR_PWR: begin
                    pwr_rf_nxt = wr_data_r[`SSPP_PWR_RF_BIT];
                    pwr_if_nxt = wr_data_r[`SSPP_PWR_IF_BIT];
                end
                `SSPP_ADDR_MAIN: begin
                    if_div_nxt = sspp_pkg::sspp_if_div_t'(
                        wr_data_r[`SSPP_IFDIV_LSB +: `SSPP_IFDIV_W]);
                end
                default: begin
                end
            endcase
        end
        // rf2 select in its own flop so both selects leave the block registered
        rf2_sel_nxt = ~rf1_sel_nxt;
        // loop power combines its control bit with the powerdown pin
        rf_on_nxt = pwr_rf_nxt & pdn_n_s;
        if_on_nxt = pwr_if_nxt & pdn_n_s;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rf1_sel_r <= `SSPP_RF1_SEL_RST;
            rf2_sel_r <= ~`SSPP_RF1_SEL_RST;
            pwr_rf_r  <= `SSPP_PWR_RST;
            pwr_if_r  <= `SSPP_PWR_RST;
            if_div_r  <= sspp_pkg::sspp_if_div_t'(`SSPP_IFDIV_RST);
            rf_on_r   <= 1'b0;
            if_on_r   <= 1'b0;
            rf_freq_r <= 1'b0;
            if_freq_r <= 1'b0;
        end else begin
            rf1_sel_r <= rf1_sel_nxt;
            rf2_sel_r <= rf2_sel_nxt;
            pwr_rf_r  <= pwr_rf_nxt;
            pwr_if_r  <= pwr_if_nxt;
            if_div_r  <= if_div_nxt;
            rf_on_r   <= rf_on_nxt;
            if_on_r   <= if_on_nxt;
            rf_freq_r <= rf_freq_nxt;
            if_freq_r <= if_freq_nxt;
        end
    end

    // tune start on powerup edge, or on a new frequency while powered;
    // a frequency write to a dark loop is picked up by its later powerup
    logic [1:0] loop_on;
    logic [1:0] loop_on_nxt;
    logic [1:0] loop_freq;
    logic [1:0] loop_tick;
    logic [1:0] loop_busy;

    assign loop_on     = {if_on_r, rf_on_r};
    assign loop_on_nxt = {if_on_nxt, rf_on_nxt};
    assign loop_freq   = {if_freq_r, rf_freq_r};
    assign loop_tick   = {pd_tick_if, pd_tick_rf};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_loop
            logic tune_start;
            assign tune_start = (loop_on_nxt[gi] & ~loop_on[gi])
                              | (loop_freq[gi] & loop_on[gi]);
            sspp_tune_timer #(
                .PERIODS (TUNE_PERIODS)
            ) u_tune (
                .clk     (clk),
                .rstn    (rstn),
                .start   (tune_start),
                .abort   (~loop_on_nxt[gi]), // next value: a powerup start is not cancelled
                .pd_tick (loop_tick[gi]),
                .busy    (loop_busy[gi])
            );
        end
    endgenerate

    // outputs straight from flip-flops
    assign rf1_active = rf1_sel_r;
    assign rf2_active = rf2_sel_r;
    assign rf_loop_on = rf_on_r;
    assign if_loop_on = if_on_r;
    assign if_div_sel = if_div_r;
    assign rf_tuning  = loop_busy[0];
    assign if_tuning  = loop_busy[1];
    assign wr_stb     = wr_stb_r;
    assign wr_addr    = wr_addr_r;
    assign wr_data    = wr_data_r;

endmodule // sspp_top

// [core/sspp_tune_timer.sv]
// self-tune sequencer for one loop: holds busy for a fixed number of
// phase-detector update periods after a start request
// assumes start, abort and pd_tick are same-clock one-cycle pulses/levels
`timescale 1ns/100ps
`include "sspp_params.svh"

module sspp_tune_timer #(
    parameter int PERIODS = `SSPP_TUNE_PERIODS
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic start,
    input  wire logic abort,
    input  wire logic pd_tick,
    output logic      busy
);

    localparam int CW = $clog2(PERIODS + 1);

    sspp_pkg::sspp_tune_state_t state_r;
    sspp_pkg::sspp_tune_state_t state_nxt;
    logic [CW-1:0]              cnt_r;
    logic [CW-1:0]              cnt_nxt;
    logic                       busy_r;
    logic                       busy_nxt;

    // a new start restarts the count, so a retune ends early only on abort
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            sspp_pkg::SSPP_TUNE_IDLE: begin
                if (start && !abort) begin
                    state_nxt = sspp_pkg::SSPP_TUNE_RUN;
                    cnt_nxt   = CW'(PERIODS);
                end
            end
            sspp_pkg::SSPP_TUNE_RUN: begin
                if (abort) begin
                    state_nxt = sspp_pkg::SSPP_TUNE_IDLE;
                    cnt_nxt   = '0;
                end else if (start) begin
                    cnt_nxt = CW'(PERIODS);
                end else if (pd_tick) begin
                    cnt_nxt = cnt_r - CW'(1);
                    if (cnt_r == CW'(1)) begin
                        state_nxt = sspp_pkg::SSPP_TUNE_IDLE;
                    end
                end
            end
        endcase
        busy_nxt = (state_nxt == sspp_pkg::SSPP_TUNE_RUN);
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= sspp_pkg::SSPP_TUNE_IDLE;
            cnt_r   <= '0;
            busy_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            busy_r  <= busy_nxt;
        end
    end

    assign busy = busy_r;

endmodule // sspp_tune_timer

// [verif/sspp_host.sv]
// host model driving the three programming pins of the port
// assumes clk is the port clock; tasks are called from the bench
`timescale 1ns/100ps

module sspp_host (
    input  wire logic clk,
    output logic      sclk,
    output logic      serial_in,
    output logic      load_strobe_n
);
    // idle pins: shift clock still, strobe high
    initial begin
        sclk          = 1'h0;
        serial_in     = 1'h0;
        load_strobe_n = 1'h1;
    end

    // one bit, set up while sclk low; 4 clk per phase leaves margin
    task automatic put_bit(input logic b);
        serial_in <= b;
        repeat (4) @(posedge clk);
        sclk <= 1'h1;
        repeat (4) @(posedge clk);
        sclk <= 1'h0;
    endtask

    // word msb first, data then address, optional leading junk bits
    task automatic send(input logic [21:0] w, input logic [3:0] lead, input logic extra);
        @(posedge clk);
        load_strobe_n <= 1'h0;
        if (extra) for (int i = 3; i >= 0; i--) put_bit(lead[i]);
        for (int i = 21; i >= 0; i--) put_bit(w[i]);
        repeat (4) @(posedge clk);
        load_strobe_n <= 1'h1;
        serial_in     <= ~serial_in; // released line must not keep last bit
    endtask

    // strobe pulse with no bits shifted
    task automatic empty();
        @(posedge clk);
        load_strobe_n <= 1'h0;
        repeat (8) @(posedge clk);
        load_strobe_n <= 1'h1;
    endtask

    // clock and data wiggle with strobe high
    task automatic noise();
        @(posedge clk);
        for (int i = 0; i < 4; i++) put_bit(i[0]);
    endtask
endmodule // sspp_host

// [verif/sspp_monitor.sv]
// checker for the serial programming port, watching sspp_top ports only
// assumes one clk domain with synchronous active-low rstn
`timescale 1ns/100ps
`include "sspp_params.svh"

module sspp_monitor #(
    parameter int WORD_W       = `SSPP_WORD_W,
    parameter int TUNE_PERIODS = `SSPP_TUNE_PERIODS
) (
    input wire logic                     clk,
    input wire logic                     rstn,
    input wire logic                     sclk,
    input wire logic                     serial_in,
    input wire logic                     load_strobe_n,
    input wire logic                     powerdown_pin_n,
    input wire logic                     pd_tick_rf,
    input wire logic                     pd_tick_if,
    input wire logic                     rf1_active,
    input wire logic                     rf2_active,
    input wire logic                     rf_loop_on,
    input wire logic                     if_loop_on,
    input wire logic [`SSPP_IFDIV_W-1:0] if_div_sel,
    input wire logic                     rf_tuning,
    input wire logic                     if_tuning,
    input wire logic                     wr_stb,
    input wire logic [`SSPP_ADDR_W-1:0]  wr_addr,
    input wire logic [`SSPP_DATA_W-1:0]  wr_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_rf_one; rf1_active != rf2_active; endproperty
    a_rf_one: assert property (p_rf_one) else $error("rf loops not exclusive");
    property p_stb_one; wr_stb |=> !wr_stb; endproperty
    a_stb_one: assert property (p_stb_one) else $error("write pulse too long");
    property p_hold; !wr_stb |-> $stable(wr_addr) && $stable(wr_data); endproperty
    a_hold: assert property (p_hold) else $error("latched word moved");
    property p_load; $rose(load_strobe_n) |-> ##[3:5] wr_stb; endproperty
    a_load: assert property (p_load) else $error("no latch after strobe");
    property p_sel1; wr_stb && (wr_addr == 4'h3 || wr_addr == 4'h6) |=> rf1_active; endproperty
    a_sel1: assert property (p_sel1) else $error("rf1 not selected");
    property p_sel2; wr_stb && (wr_addr == 4'h4 || wr_addr == 4'h7) |=> rf2_active; endproperty
    a_sel2: assert property (p_sel2) else $error("rf2 not selected");
    property p_div; wr_stb && wr_addr == 4'h0 |=> if_div_sel == $past(wr_data[11:10]); endproperty
    a_div: assert property (p_div) else $error("if divide not taken");
    property p_off; wr_stb && wr_addr == 4'h2 && !wr_data[0] |=> !rf_loop_on; endproperty
    a_off: assert property (p_off) else $error("rf loop stayed on");
    property p_tune; $rose(rf_loop_on) |=> rf_tuning; endproperty
    a_tune: assert property (p_tune) else $error("no tune on powerup");
    property p_end; $fell(if_tuning) && if_loop_on |-> $past(pd_tick_if); endproperty
    a_end: assert property (p_end) else $error("tune ended off a tick");
    property p_pin; !powerdown_pin_n [*4] |-> !rf_loop_on && !if_loop_on; endproperty
    a_pin: assert property (p_pin) else $error("pin did not power down");
endmodule // sspp_monitor

bind sspp_top sspp_monitor #(.WORD_W(WORD_W), .TUNE_PERIODS(TUNE_PERIODS)) u_mon (
    .clk(clk), .rstn(rstn), .sclk(sclk), .serial_in(serial_in),
    .load_strobe_n(load_strobe_n), .powerdown_pin_n(powerdown_pin_n),
    .pd_tick_rf(pd_tick_rf), .pd_tick_if(pd_tick_if), .rf1_active(rf1_active),
    .rf2_active(rf2_active), .rf_loop_on(rf_loop_on), .if_loop_on(if_loop_on),
    .if_div_sel(if_div_sel), .rf_tuning(rf_tuning), .if_tuning(if_tuning),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data));

// [verif/sspp_top_tb.sv]
// self-checking bench for sspp_top with a host pin model
// assumes the bound checker; tune length shortened to 2 periods
`timescale 1ns/100ps
`include "sspp_params.svh"

module sspp_top_tb;
    typedef struct packed {logic [21:0] w; logic rf1; logic [1:0] div;} sspp_row_t;
    localparam int TP = 2;
    logic       clk = 1'h0;
    logic       rstn = 1'h0;
    logic       pin_n = 1'h1;
    logic       tick = 1'h0;
    logic       sclk, serial_in, load_strobe_n;
    logic       rf1_active, rf2_active, rf_loop_on, if_loop_on, rf_tuning, if_tuning;
    logic       wr_stb;
    logic [1:0] if_div_sel;
    logic [3:0] wr_addr;
    logic [17:0] wr_data;
    int         n_errors, n_compared, n_wr;
    sspp_row_t  rows [10] = '{
        {18'h00123, 4'h3, 1'h1, 2'h0}, {18'h2a5c3, 4'h4, 1'h0, 2'h0},
        {18'h00400, 4'h0, 1'h0, 2'h1}, {18'h00800, 4'h0, 1'h0, 2'h2},
        {18'h3fc00, 4'h0, 1'h0, 2'h3}, {18'h00123, 4'h6, 1'h1, 2'h3},
        {18'h15555, 4'h7, 1'h0, 2'h3}, {18'h00000, 4'h0, 1'h0, 2'h0},
        {18'h3ffff, 4'h3, 1'h1, 2'h0}, {18'h0abcd, 4'h9, 1'h1, 2'h0}};

    // 125 MHz clock
    always #4 clk = ~clk;

    // latch pulses seen
    always @(posedge clk) if (wr_stb === 1'h1) n_wr <= n_wr + 1;

    sspp_host u_host (.clk(clk), .sclk(sclk), .serial_in(serial_in),
        .load_strobe_n(load_strobe_n));

    sspp_top #(.TUNE_PERIODS(TP)) u_dut (
        .clk(clk), .rstn(rstn), .sclk(sclk), .serial_in(serial_in),
        .load_strobe_n(load_strobe_n), .powerdown_pin_n(pin_n), .pd_tick_rf(tick),
        .pd_tick_if(tick), .rf1_active(rf1_active), .rf2_active(rf2_active),
        .rf_loop_on(rf_loop_on), .if_loop_on(if_loop_on), .if_div_sel(if_div_sel),
        .rf_tuning(rf_tuning), .if_tuning(if_tuning), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // wait n edges, then step past them so outputs have settled
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // one-cycle update ticks to both loops, one per two clocks
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'h1;
            @(posedge clk);
            tick <= 1'h0;
        end
    endtask

    task automatic tuning_is(input logic v);
        check(rf_tuning, v, "rf tune");
        check(if_tuning, v, "if tune");
    endtask

    task automatic close_out();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog well above the few thousand cycles the run needs
    initial begin
        #400000;
        n_errors++;
        close_out();
    end

    initial begin
        wait_n(5);
        check(rf1_active, 1'h1, "rst rf1");
        check(rf2_active, 1'h0, "rst rf2");
        check({wr_stb, if_div_sel, rf_loop_on}, 4'h0, "rst outs");
        @(posedge clk);
        rstn <= 1'h1;
        wait_n(7);
        tuning_is(1'h1);
        ticks(TP - 1);
        wait_n(2);
        tuning_is(1'h1);
        ticks(1);
        wait_n(2);
        tuning_is(1'h0);
        // latch timing: result settles 4 clk after strobe rise
        for (int i = 0; i < 10; i++) begin
            u_host.send(rows[i].w, 4'h0, 1'h0);
            wait_n(8);
            check(n_wr, i + 1, "pulses");
            check(wr_addr, rows[i].w[3:0], "addr");
            check(wr_data, rows[i].w[21:4], "data");
            check(rf1_active, rows[i].rf1, "rf1");
            check(rf2_active, !rows[i].rf1, "rf2");
            check(if_div_sel, rows[i].div, "div");
        end
        ticks(TP);
        u_host.send({18'h01234, 4'h7}, 4'h3, 1'h1);
        wait_n(8);
        check({wr_data, wr_addr}, {18'h01234, 4'h7}, "long");
        u_host.noise();
        wait_n(8);
        check(n_wr, 11, "noise");
        u_host.empty();
        wait_n(8);
        check({wr_data, wr_addr}, {18'h01234, 4'h7}, "kept");
        u_host.send({18'h00000, 4'h2}, 4'h0, 1'h0);
        wait_n(8);
        check({rf_loop_on, if_loop_on}, 2'h0, "pwr off");
        u_host.send({18'h00003, 4'h2}, 4'h0, 1'h0);
        wait_n(8);
        check({rf_loop_on, if_loop_on}, 2'h3, "pwr on");
        tuning_is(1'h1);
        ticks(TP);
        // an rf frequency write retunes the rf loop only
        u_host.send({18'h00042, 4'h4}, 4'h0, 1'h0);
        wait_n(8);
        check({rf_tuning, if_tuning}, 2'h2, "new freq");
        ticks(TP);
        // an if frequency write retunes the if loop only
        u_host.send({18'h00010, `SSPP_ADDR_IF_R}, 4'h0, 1'h0);
        wait_n(8);
        check({rf_tuning, if_tuning}, 2'h1, "if freq");
        ticks(TP);
        pin_n <= 1'h0;
        wait_n(6);
        check({rf_loop_on, if_loop_on}, 2'h0, "pin off");
        @(posedge clk);
        pin_n <= 1'h1;
        wait_n(6);
        tuning_is(1'h1);
        ticks(TP);
        // mid-run reset must undo written state: rf2 selected, divide by eight
        u_host.send({18'h00c00, `SSPP_ADDR_MAIN}, 4'h0, 1'h0);
        wait_n(8);
        check({rf1_active, if_div_sel}, 3'h3, "pre rst");
        @(posedge clk);
        rstn <= 1'h0;
        wait_n(2);
        check({rf1_active, rf2_active}, 2'h2, "mid rst sel");
        check({wr_stb, if_div_sel, wr_addr, wr_data}, 25'h0, "mid rst outs");
        @(posedge clk);
        rstn <= 1'h1;
        wait_n(7);
        check({rf_loop_on, if_loop_on}, 2'h3, "rst pwr");
        tuning_is(1'h1);
        ticks(TP);
        close_out();
    end
endmodule // sspp_top_tb
